// >>> smio_glue.sv
/*
  Host I/O glue: decodes host I/O cycles for the input and output converters,
  the serial link adapter and the interrupt select port, paces sampling and
  makes the shared converter and serial clock.
  Assumes all host, converter and serial adapter pins are asynchronous to
  sys_clk and that host I/O strobes last many sys_clk cycles.
*/
`timescale 1ns/1ps
module smio_glue #(
  parameter int unsigned PACE_CYC = smio_pkg::PACE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] host_addr,
  input  wire logic        host_iorq_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [7:0]  host_d_i,
  output logic [7:0]       host_d_o,
  output logic             host_d_oe,
  input  wire logic        host_int_src_n,
  output logic             host_int_n,
  input  wire logic [7:0]  adc_d,
  input  wire logic        adc_eoc,
  output logic             adc_start,
  output logic             conv_clk,
  output logic             sample_pace,
  output logic [7:0]       dac_d,
  input  wire logic [7:0]  ser_d_i,
  output logic [7:0]       ser_d_o,
  output logic             ser_cs,
  output logic             ser_read,
  output logic             ser_rs_data,
  input  wire logic        ser_irq_n,
  output logic             note_valid,
  output logic             note_on,
  output logic [3:0]       note_channel,
  output logic [6:0]       note_pitch,
  output logic [6:0]       drum_index,
  output logic             drum_valid
);
  import smio_pkg::*;

  localparam logic [15:0] PACE_LAST = 16'(PACE_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    smio_pins_t  s1;
    smio_pins_t  s2;
    smio_bus_t   bus;
    logic [15:0] addr;
    logic        adc_start;
    logic        eoc_prev;
    logic [7:0]  adc_result;
    logic [7:0]  dac;
    logic        int_sel;
    logic        int_n;
    logic [7:0]  d_o;
    logic        d_oe;
    logic        ser_cs;
    logic        ser_read;
    logic        ser_rs_data;
    logic [7:0]  ser_wd;
    logic [7:0]  osc_cnt;
    logic        conv_clk;
    logic [15:0] pace_cnt;
    logic        pace;
    logic [7:0]  rx_byte;
    logic        rx_valid;
  } smio_glue_state_t;

  smio_glue_state_t r;
  smio_glue_state_t next_r;
  smio_pins_t       pins;

  smio_midi_if mi ();

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Converter ports only look at the low byte so plain 8-bit I/O reaches them
  function automatic logic hit_conv(input logic [15:0] a, input logic [15:0] off);
    hit_conv = (a[7:0] == off[7:0]);
  endfunction

  function automatic logic hit_full(input logic [15:0] a, input logic [15:0] off);
    hit_full = (a == off);
  endfunction

  function automatic logic ser_rd_hit(input logic [15:0] a);
    ser_rd_hit = hit_full(a, OFF_SER_STAT) || hit_full(a, OFF_SER_RX);
  endfunction

  function automatic logic ser_wr_hit(input logic [15:0] a);
    ser_wr_hit = hit_full(a, OFF_SER_TX) || hit_full(a, OFF_SER_CTRL);
  endfunction

  function automatic logic readable(input logic [15:0] a);
    readable = ser_rd_hit(a) || hit_conv(a, OFF_ADC_READ) || hit_conv(a, OFF_ADC_START);
  endfunction

  function automatic logic [7:0] read_mux(input smio_glue_state_t s, input logic [15:0] a);
    if (ser_rd_hit(a)) begin
      read_mux = s.s2.ser_d;
    end else begin
      read_mux = s.adc_result;
    end
  endfunction

  assign pins = '{addr: host_addr, iorq_n: host_iorq_n, rd_n: host_rd_n,
                  wr_n: host_wr_n, d: host_d_i, ser_d: ser_d_i,
                  ser_irq_n: ser_irq_n, int_src_n: host_int_src_n,
                  adc_d: adc_d, eoc: adc_eoc};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.s1        = pins;
    next_r.s2        = r.s1;
    next_r.adc_start = 1'b0;
    next_r.rx_valid  = 1'b0;
    next_r.pace      = 1'b0;

    // Shared 500 kHz clock for the serial adapter and input converter
    if (r.osc_cnt == OSC_HALF_CYC - 8'h01) begin
      next_r.osc_cnt  = 8'h00;
      next_r.conv_clk = ~r.conv_clk;
    end else begin
      next_r.osc_cnt = r.osc_cnt + 8'h01;
    end

    // Sample pacing strobe; software starts a conversion on each one
    if (r.pace_cnt == PACE_LAST) begin
      next_r.pace_cnt = 16'h0000;
      next_r.pace     = 1'b1;
    end else begin
      next_r.pace_cnt = r.pace_cnt + 16'h0001;
    end

    // Keep the last finished conversion; reads never disturb it
    next_r.eoc_prev = r.s2.eoc;
    if (r.s2.eoc && !r.eoc_prev) begin
      next_r.adc_result = r.s2.adc_d;
    end

    // Registered interrupt routing so the host line is glitch free
    if (r.int_sel) begin
      next_r.int_n = r.s2.ser_irq_n;
    end else begin
      next_r.int_n = r.s2.int_src_n;
    end

    case (r.bus)
      BUS_IDLE: begin
        next_r.d_oe   = 1'b0;
        next_r.ser_cs = 1'b0;
        if (!r.s2.iorq_n && (!r.s2.rd_n || !r.s2.wr_n)) begin
          next_r.addr = r.s2.addr;
          if (hit_conv(r.s2.addr, OFF_ADC_START)) begin
            next_r.adc_start = 1'b1;
          end
          if (!r.s2.rd_n) begin
            next_r.bus         = BUS_RD;
            next_r.d_oe        = readable(r.s2.addr);
            next_r.d_o         = read_mux(r, r.s2.addr);
            next_r.ser_cs      = ser_rd_hit(r.s2.addr);
            next_r.ser_read    = 1'b1;
            next_r.ser_rs_data = hit_full(r.s2.addr, OFF_SER_RX);
          end else begin
            next_r.bus         = BUS_WR;
            next_r.ser_cs      = ser_wr_hit(r.s2.addr);
            next_r.ser_read    = 1'b0;
            next_r.ser_rs_data = hit_full(r.s2.addr, OFF_SER_TX);
            next_r.ser_wd      = r.s2.d;
            if (hit_conv(r.s2.addr, OFF_DAC)) begin
              next_r.dac = r.s2.d;
            end
            if (hit_full(r.s2.addr, OFF_INT_SEL)) begin
              // Values other than the two defined codes leave the setting alone
              if (r.s2.d == INT_SEL_SERIAL) begin
                next_r.int_sel = 1'b1;
              end else if (r.s2.d == INT_SEL_NORMAL) begin
                next_r.int_sel = 1'b0;
              end
            end
          end
        end
      end
      BUS_RD: begin
        next_r.d_o = read_mux(r, r.addr);
        if (r.s2.iorq_n || r.s2.rd_n) begin
          next_r.bus    = BUS_IDLE;
          next_r.d_oe   = 1'b0;
          next_r.ser_cs = 1'b0;
          // The decoder sees exactly the bytes that software took out
          if (hit_full(r.addr, OFF_SER_RX)) begin
            next_r.rx_byte  = r.d_o;
            next_r.rx_valid = 1'b1;
          end
        end
      end
      BUS_WR: begin
        if (r.s2.iorq_n || r.s2.wr_n) begin
          next_r.bus    = BUS_IDLE;
          next_r.ser_cs = 1'b0;
        end
      end
      default: begin
        next_r.bus    = BUS_IDLE;
        next_r.d_oe   = 1'b0;
        next_r.ser_cs = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r             <= '0;
      r.bus         <= BUS_IDLE;
      r.s1.iorq_n   <= 1'b1;
      r.s2.iorq_n   <= 1'b1;
      r.s1.rd_n     <= 1'b1;
      r.s2.rd_n     <= 1'b1;
      r.s1.wr_n     <= 1'b1;
      r.s2.wr_n     <= 1'b1;
      // Interrupt inputs idle high so the host line does not pulse after reset
      r.s1.int_src_n <= 1'b1;
      r.s2.int_src_n <= 1'b1;
      r.s1.ser_irq_n <= 1'b1;
      r.s2.ser_irq_n <= 1'b1;
      r.int_sel     <= RST_INT_SEL;
      r.int_n       <= 1'b1;
      r.dac         <= RST_DAC;
      r.adc_result  <= RST_ADC_RESULT;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Note decoder
  // ----------------------------------------------------------------
  assign mi.rx_byte  = r.rx_byte;
  assign mi.rx_valid = r.rx_valid;

  smio_midi_parse u_parse (
    .sys_clk (sys_clk),
    .rst     (rst),
    .m       (mi)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_d_o     = r.d_o;
  assign host_d_oe    = r.d_oe;
  assign host_int_n   = r.int_n;
  assign adc_start    = r.adc_start;
  assign conv_clk     = r.conv_clk;
  assign sample_pace  = r.pace;
  assign dac_d        = r.dac;
  assign ser_d_o      = r.ser_wd;
  assign ser_cs       = r.ser_cs;
  assign ser_read     = r.ser_read;
  assign ser_rs_data  = r.ser_rs_data;
  assign note_valid   = mi.note_valid;
  assign note_on      = mi.note_on;
  assign note_channel = mi.channel;
  assign note_pitch   = mi.pitch;
  assign drum_index   = mi.drum;
  assign drum_valid   = mi.drum_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_access_start;
    r.bus == BUS_IDLE && !r.s2.iorq_n && (!r.s2.rd_n || !r.s2.wr_n);
  endsequence

  sequence s_dac_write;
    s_access_start ##0 r.s2.rd_n && hit_conv(r.s2.addr, OFF_DAC);
  endsequence

  sequence s_rx_read_end;
    r.bus == BUS_RD && hit_full(r.addr, OFF_SER_RX) && (r.s2.iorq_n || r.s2.rd_n);
  endsequence

  property p_start_conv;
    s_access_start ##0 hit_conv(r.s2.addr, OFF_ADC_START) |=> r.adc_start ##1 !r.adc_start;
  endproperty
  a_start_conv: assert property (p_start_conv)
    else $error("start port access gave no single start pulse");

  property p_start_cause;
    r.adc_start |-> $past(r.bus == BUS_IDLE && hit_conv(r.s2.addr, OFF_ADC_START));
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("conversion started without a start port access");

  property p_result_read;
    r.bus == BUS_RD && hit_conv(r.addr, OFF_ADC_READ) |-> r.d_oe && r.d_o == $past(r.adc_result);
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("result read does not show the stored result");

  property p_dac_load;
    s_dac_write |=> r.dac == $past(r.s2.d);
  endproperty
  a_dac_load: assert property (p_dac_load)
    else $error("output converter not loaded with written byte");

  property p_int_serial;
    r.int_sel && $past(r.int_sel) |=> r.int_n == $past(r.s2.ser_irq_n);
  endproperty
  a_int_serial: assert property (p_int_serial)
    else $error("host interrupt not following serial request");

  property p_int_normal;
    !r.int_sel && $past(!r.int_sel) |=> r.int_n == $past(r.s2.int_src_n);
  endproperty
  a_int_normal: assert property (p_int_normal)
    else $error("host interrupt not following internal source");

  property p_sel_hold;
    $changed(r.int_sel) |-> $past(r.bus == BUS_IDLE && !r.s2.wr_n && !r.s2.iorq_n &&
                                  hit_full(r.s2.addr, OFF_INT_SEL));
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("interrupt select changed without a write");

  property p_ser_dir;
    r.ser_cs |-> (r.ser_read ? ser_rd_hit(r.addr) : ser_wr_hit(r.addr));
  endproperty
  a_ser_dir: assert property (p_ser_dir)
    else $error("serial adapter selected for a forbidden direction");

  property p_osc_half;
    $changed(r.conv_clk) |-> $past(r.osc_cnt) == OSC_HALF_CYC - 8'h01;
  endproperty
  a_osc_half: assert property (p_osc_half)
    else $error("converter clock half period wrong");

  property p_rx_feed;
    s_rx_read_end |=> r.rx_valid && r.rx_byte == $past(r.d_o) ##1 !r.rx_valid;
  endproperty
  a_rx_feed: assert property (p_rx_feed)
    else $error("received byte not passed to note decoder");

  property p_pace;
    r.pace |-> $past(r.pace_cnt) == PACE_LAST;
  endproperty
  a_pace: assert property (p_pace)
    else $error("sample pacing strobe at wrong count");
endmodule

// >>> smio_pkg.sv
/*
  Constants, register map and shared types for the sampler host I/O glue.
  Assumes one 250 MHz system clock and a host I/O bus whose pins are
  synchronised inside the top module before use.
*/
// Operation
// - Any read or write to the start port begins a new conversion.
// - Reading the result port returns the 8-bit conversion result; reads only.
// - Writing the output converter port loads the byte into the converter.
// - Writing 01 to the select port routes the serial interrupt to the host.
// - Writing 0 to the select port restores the internal interrupt source.
// - Serial ports decode all 16 address bits; converter ports decode 8 bits.
// - Serial status and receive data read-only; control and transmit write-only.
// - Audio sampled to 8 bits at 19.444 thousand samples per second.
// - One 500 kHz oscillator clocks both the serial adapter and input converter.
// - Only note-on and note-off, each three bytes long, are handled.
// - Note-on status byte is 1001 followed by the channel bits.
// - Channel bits hold channel minus one: 0000 is 1, 1111 is 16.
// - Second byte is a 7-bit pitch; 0010 0000 is middle C.
// - Velocity zero means note off, nonzero means on; no volume effect.
// - Note-off status is 1000 plus channel; its velocity byte is ignored.
// - Drum number follows note: middle C is drum 1, C sharp drum 2.
package smio_pkg;

  // ----------------------------------------------------------------
  // I/O map
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_INT_SEL   = 16'hf8e8;
  localparam logic [15:0] OFF_SER_TX    = 16'hf8ec;
  localparam logic [15:0] OFF_SER_CTRL  = 16'hf8ed;
  localparam logic [15:0] OFF_SER_STAT  = 16'hf8ee;
  localparam logic [15:0] OFF_SER_RX    = 16'hf8ef;
  localparam logic [15:0] OFF_DAC       = 16'hf8f0;
  localparam logic [15:0] OFF_ADC_READ  = 16'hf8f4;
  localparam logic [15:0] OFF_ADC_START = 16'hf8f8;

  localparam logic [7:0]  INT_SEL_SERIAL = 8'h01;
  localparam logic [7:0]  INT_SEL_NORMAL = 8'h00;
  localparam logic        RST_INT_SEL    = 1'b0;
  localparam logic [7:0]  RST_DAC        = 8'h00;
  localparam logic [7:0]  RST_ADC_RESULT = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ   = 250_000_000;
  localparam int unsigned OSC_HZ       = 500_000;
  localparam logic [7:0]  OSC_HALF_CYC = 8'(SYS_CLK_HZ / (2 * OSC_HZ));
  localparam int unsigned SAMPLE_SPS   = 19444;
  localparam int unsigned PACE_CYCLES  = SYS_CLK_HZ / SAMPLE_SPS;
  localparam int unsigned CONV_TIME_US = 20;

  // ----------------------------------------------------------------
  // MIDI note events
  // ----------------------------------------------------------------
  localparam logic [3:0] MIDI_NOTE_ON  = 4'h9;
  localparam logic [3:0] MIDI_NOTE_OFF = 4'h8;
  localparam logic [6:0] MIDI_MIDDLE_C = 7'h20;
  localparam logic [6:0] DRUM_FIRST    = 7'h01;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RD   = 3'b010,
    BUS_WR   = 3'b100
  } smio_bus_t;

  typedef enum logic [2:0] {
    P_STATUS = 3'b001,
    P_PITCH  = 3'b010,
    P_VEL    = 3'b100
  } smio_parse_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        iorq_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  d;
    logic [7:0]  ser_d;
    logic        ser_irq_n;
    logic        int_src_n;
    logic [7:0]  adc_d;
    logic        eoc;
  } smio_pins_t;

endpackage

// >>> smio_midi_if.sv
/*
  Carrier between the bus glue and the MIDI note decoder.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface smio_midi_if;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       note_valid;
  logic       note_on;
  logic [3:0] channel;
  logic [6:0] pitch;
  logic [6:0] drum;
  logic       drum_valid;

  modport feed  (output rx_byte, rx_valid,
                 input  note_valid, note_on, channel, pitch, drum, drum_valid);
  modport parse (input  rx_byte, rx_valid,
                 output note_valid, note_on, channel, pitch, drum, drum_valid);
endinterface

// >>> smio_midi_parse.sv
/*
  Decodes received MIDI bytes into note events and drum numbers.
  Assumes bytes arrive as one-cycle strobes, in order, from the bus glue.
*/
`timescale 1ns/1ps
module smio_midi_parse (
  input  wire logic sys_clk,
  input  wire logic rst,
  smio_midi_if.parse m
);
  import smio_pkg::*;

  typedef struct packed {
    smio_parse_t st;
    logic [3:0]  kind;
    logic [3:0]  chan;
    logic [6:0]  pend_pitch;
    logic        note_valid;
    logic        note_on;
    logic [3:0]  channel;
    logic [6:0]  pitch;
    logic [6:0]  drum;
    logic        drum_valid;
  } smio_parse_state_t;

  smio_parse_state_t r;
  smio_parse_state_t next_r;

  function automatic logic [6:0] drum_of(input logic [6:0] p);
    drum_of = 7'(p - MIDI_MIDDLE_C + DRUM_FIRST);
  endfunction

  always_comb begin
    next_r = r;
    next_r.note_valid = 1'b0;
    if (m.rx_valid) begin
      if (m.rx_byte[7]) begin
        // Other status bytes are not supported and drop the running status
        if (m.rx_byte[7:4] == MIDI_NOTE_ON || m.rx_byte[7:4] == MIDI_NOTE_OFF) begin
          next_r.kind = m.rx_byte[7:4];
          next_r.chan = m.rx_byte[3:0];
          next_r.st   = P_PITCH;
        end else begin
          next_r.st = P_STATUS;
        end
      end else begin
        case (r.st)
          P_STATUS: begin
            next_r.st = P_STATUS;
          end
          P_PITCH: begin
            next_r.pend_pitch = m.rx_byte[6:0];
            next_r.st         = P_VEL;
          end
          P_VEL: begin
            next_r.note_valid = 1'b1;
            next_r.note_on    = (r.kind == MIDI_NOTE_ON) && (m.rx_byte[6:0] != 7'h00);
            next_r.channel    = r.chan;
            next_r.pitch      = r.pend_pitch;
            next_r.drum_valid = (r.pend_pitch >= MIDI_MIDDLE_C);
            next_r.drum       = drum_of(r.pend_pitch);
            next_r.st         = P_PITCH;
          end
          default: begin
            next_r.st = P_STATUS;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r    <= '0;
      r.st <= P_STATUS;
    end else begin
      r <= next_r;
    end
  end

  assign m.note_valid = r.note_valid;
  assign m.note_on    = r.note_on;
  assign m.channel    = r.channel;
  assign m.pitch      = r.pitch;
  assign m.drum       = r.drum;
  assign m.drum_valid = r.drum_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_velocity_byte;
    m.rx_valid && !m.rx_byte[7] && r.st == P_VEL;
  endsequence

  property p_velocity_zero;
    @(posedge sys_clk) disable iff (rst)
    s_velocity_byte |=> r.note_valid && (r.note_on ==
      ($past(r.kind) == MIDI_NOTE_ON && $past(m.rx_byte[6:0]) != 7'h00));
  endproperty
  a_velocity_zero: assert property (p_velocity_zero)
    else $error("note on/off decision wrong");

  property p_drum_map;
    @(posedge sys_clk) disable iff (rst)
    r.note_valid && r.drum_valid |-> r.drum == 7'(r.pitch - MIDI_MIDDLE_C + 7'h01);
  endproperty
  a_drum_map: assert property (p_drum_map)
    else $error("drum number does not follow pitch");
endmodule

// >>> smio_host_model.sv
/*
  Host I/O bus master model: one I/O cycle per call of io().
  Assumes a free-running sys_clk and a caller that waits for io() to return.
*/
`timescale 1ns/1ps
module smio_host_model (
  input  wire logic        sys_clk,
  output logic [15:0]      host_addr,
  output logic             host_iorq_n,
  output logic             host_rd_n,
  output logic             host_wr_n,
  output logic [7:0]       host_d_i,
  input  wire logic [7:0]  host_d_o,
  input  wire logic        host_d_oe
);
  initial begin
    host_addr = 16'h0000;
    host_d_i = 8'h00;
    {host_iorq_n, host_rd_n, host_wr_n} = 3'b111;
  end

  // Released lines show the inverse of the last value so stale data cannot match
  task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] wd,
                    output logic [7:0] rd, output logic oe);
    @(negedge sys_clk);
    host_addr = a;
    host_d_i = wr ? wd : ~host_d_i;
    {host_iorq_n, host_rd_n, host_wr_n} = {1'b0, wr, ~wr};
    repeat (6) @(negedge sys_clk);
    rd = host_d_o;
    oe = host_d_oe;
    {host_iorq_n, host_rd_n, host_wr_n} = 3'b111;
    host_addr = ~a;
    host_d_i = ~host_d_i;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule

// >>> sampler_midi_io_glue_tb.sv
/*
  Self-checking bench for the sampler host I/O glue.
  Assumes smio_pkg, smio_midi_if, smio_midi_parse, smio_glue and smio_host_model.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module sampler_midi_io_glue_tb;
  import smio_pkg::*;
  localparam int PACE  = 20;
  localparam int LIMIT = 40000;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        host_int_src_n = 1'b1;
  logic        ser_irq_n = 1'b1;
  logic        adc_eoc = 1'b0;
  logic [7:0]  adc_d = 8'h00;
  logic [7:0]  ser_d_i = 8'h00;
  logic [7:0]  conv_left = 8'h00;
  logic [31:0] seed = 32'h45e8c650;
  logic [15:0] host_addr;
  logic        host_iorq_n, host_rd_n, host_wr_n, host_d_oe, host_int_n, roe, conv_prev;
  logic        adc_start, conv_clk, sample_pace, ser_cs, ser_read, ser_rs_data;
  logic        note_valid, note_on, drum_valid;
  logic [7:0]  host_d_i, host_d_o, dac_d, ser_d_o, rdata, adc_val;
  logic [3:0]  note_channel, ch;
  logic [6:0]  note_pitch, drum_index, p, vel;
  logic [19:0] last_note;
  logic [9:0]  last_ser;
  logic [31:0] v;
  int          err_total, n_compared, cyc, n_start, n_note, n_cs, n0;
  int          pace_at, pace_gap, clk_at, clk_gap;

  always #2 sys_clk = ~sys_clk;

  smio_glue #(.PACE_CYC(PACE)) uut (.sys_clk, .rst, .host_addr, .host_iorq_n, .host_rd_n,
    .host_wr_n, .host_d_i, .host_d_o, .host_d_oe, .host_int_src_n, .host_int_n, .adc_d,
    .adc_eoc, .adc_start, .conv_clk, .sample_pace, .dac_d, .ser_d_i, .ser_d_o, .ser_cs,
    .ser_read, .ser_rs_data, .ser_irq_n, .note_valid, .note_on, .note_channel,
    .note_pitch, .drum_index, .drum_valid);

  smio_host_model u_host (.sys_clk, .host_addr, .host_iorq_n, .host_rd_n, .host_wr_n,
    .host_d_i, .host_d_o, .host_d_oe);

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > LIMIT) begin
      err_total++;
      final_report();
    end
    if (adc_start) n_start++;
    if (ser_cs) begin
      n_cs++;
      last_ser <= {ser_read, ser_rs_data, ser_d_o};
    end
    if (note_valid) begin
      n_note++;
      last_note <= {note_on, note_channel, note_pitch, drum_valid, drum_index};
    end
    if (sample_pace) begin
      pace_gap <= cyc - pace_at;
      pace_at <= cyc;
    end
    conv_prev <= conv_clk;
    if (conv_clk && !conv_prev) begin
      clk_gap <= cyc - clk_at;
      clk_at <= cyc;
    end
  end

  // Converter model: result lands with end-of-conversion well inside 20 us
  always @(negedge sys_clk) begin
    if (adc_start) begin
      adc_eoc <= 1'b0;
      conv_left <= 8'h3c;
    end else if (conv_left != 8'h00) conv_left <= conv_left - 8'h01;
    if (conv_left == 8'h01) begin
      adc_eoc <= 1'b1;
      adc_d <= adc_val;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [19:0] exp_note(input logic on, input logic [3:0] c,
                                           input logic [6:0] q);
    return {on, c, q, q >= MIDI_MIDDLE_C, 7'(q - MIDI_MIDDLE_C + DRUM_FIRST)};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.io(a, 1'b1, d, rdata, roe);
  endtask

  task automatic rd(input logic [15:0] a);
    u_host.io(a, 1'b0, 8'h00, rdata, roe);
  endtask

  task automatic midi_byte(input logic [7:0] b);
    ser_d_i = b;
    rd(OFF_SER_RX);
    `CHK(rdata, b)
    ser_d_i = ~b;
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    host_int_src_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(host_int_n, 1'b0)
    host_int_src_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr({(i == 0) ? 8'h00 : v[15:8], 8'hf0}, v[23:16]);
      `CHK(dac_d, v[23:16])
    end
    rd(OFF_DAC);
    `CHK(roe, 1'b0)
    $display("test output converter done");
    adc_val = v[7:0];
    n0 = n_start;
    wr(OFF_ADC_START, v[31:24]);
    repeat (5000) @(negedge sys_clk);
    rd(OFF_ADC_READ);
    `CHK({roe, rdata}, {1'b1, adc_val})
    adc_val = ~adc_val;
    rd({8'h12, 8'hf8});
    repeat (5000) @(negedge sys_clk);
    rd(OFF_ADC_READ);
    `CHK(rdata, adc_val)
    `CHK(n_start - n0, 2)
    $display("test input converter done");
    wr(OFF_INT_SEL, INT_SEL_SERIAL);
    host_int_src_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      ser_irq_n = k[0];
      repeat (5) @(negedge sys_clk);
      `CHK(host_int_n, k[0])
    end
    wr({8'h00, 8'he8}, INT_SEL_NORMAL);
    `CHK(host_int_n, 1'b1)
    wr(OFF_INT_SEL, INT_SEL_NORMAL);
    `CHK(host_int_n, 1'b0)
    host_int_src_n = 1'b1;
    $display("test interrupt select done");
    wr(OFF_SER_TX, 8'h3c);
    `CHK(last_ser, {2'b01, 8'h3c})
    wr(OFF_SER_CTRL, 8'hc3);
    `CHK(last_ser, {2'b00, 8'hc3})
    ser_d_i = 8'h96;
    rd(OFF_SER_STAT);
    `CHK({roe, rdata, last_ser[9:8]}, {1'b1, 8'h96, 2'b10})
    n0 = n_cs;
    rd(OFF_SER_CTRL);
    rd(OFF_SER_TX);
    rd({8'h00, 8'hef});
    rd(16'h1234);
    `CHK({roe, n_cs - n0}, {1'b0, 32'h0})
    $display("test serial map done");
    for (int i = 0; i < 9; i++) begin
      v = rnd();
      ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : v[3:0];
      p = (i == 2) ? MIDI_MIDDLE_C : (i == 3) ? 7'h1f : v[10:4];
      vel = (i % 3 == 1) ? 7'h00 : (v[17:11] | 7'h01);
      n0 = n_note;
      midi_byte({(i % 3 == 2) ? MIDI_NOTE_OFF : MIDI_NOTE_ON, ch});
      midi_byte({1'b0, p});
      midi_byte({1'b0, vel});
      repeat (4) @(negedge sys_clk);
      `CHK(n_note - n0, 1)
      `CHK(last_note, exp_note(i % 3 == 0, ch, p))
    end
    $display("test note decode done");
    `CHK(clk_gap, SYS_CLK_HZ / OSC_HZ)
    `CHK(pace_gap, PACE)
    $display("test clocks done");
    final_report();
  end
endmodule
